// file: core/seesf_map.svh
// offsets, widths and timing counts of the serial eeprom slave front
`ifndef SEESF_MAP_SVH
`define SEESF_MAP_SVH

// array geometry
`define SEESF_ADDR_W        16
`define SEESF_ROW_W         9
`define SEESF_COL_W         7
`define SEESF_PAGE_BYTES    128
`define SEESF_PAGE_LAST     7'h7f

// device select byte fields
`define SEESF_SEL_TYPE_MSB  7
`define SEESF_SEL_TYPE_LSB  4
`define SEESF_SEL_CHIP_MSB  3
`define SEESF_SEL_CHIP_LSB  1
`define SEESF_SEL_RW_BIT    0

// bit slot holding the acknowledge
`define SEESF_ACK_SLOT      4'h8
`define SEESF_LAST_DATA_BIT 4'h7
// a stop after an ack comes after one more scl rise
`define SEESF_STOP_SLOT     4'h1

// pin synchroniser width and positions in the pin vector
`define SEESF_PIN_W         7
`define SEESF_PIN_SCL       0
`define SEESF_PIN_SDA       1
`define SEESF_PIN_WP        2
`define SEESF_PIN_PG        3
`define SEESF_PIN_CHIP_LSB  4
`define SEESF_PIN_CHIP_MSB  6
`define SEESF_PIN_RESET     7'h03

// timing
`define SEESF_CLK_PERIOD_NS 4
`define SEESF_WRITE_TIME_NS 5000

`endif

// file: core/seesf_pkg.sv
// types shared by the serial eeprom slave front
`default_nettype none
package seesf_pkg;
   typedef enum logic [2:0] {
      SEESF_IDLE,
      SEESF_SELECT,
      SEESF_ADDR_HI,
      SEESF_ADDR_LO,
      SEESF_WDATA,
      SEESF_RDATA
   } seesf_state_e;

   typedef logic [7:0]  seesf_byte_t;
   typedef logic [15:0] seesf_addr_t;
endpackage
`default_nettype wire

// file: core/seesf_top.sv
// two-wire slave front end and byte array of the serial eeprom
//
// Summary of operation
// R01: array holds 64K bytes, sixteen-bit addresses
// R02: slave only, timed by the master's clock
// R03: master opens with start and select byte
// R04: device acks a matching select, both address bytes and unprotected data
// R05: master acks reads, stops after ack/nack
// R06: ignore bus while supply not good
// R07: chip pins give select bits b3..b1
// R08: write protect high when the address ends blocks the writes
// R09: protected: ack select/address, nack data
// R10: select byte: type, chip, direction, msb first
// R11: address sent high byte first
// R12: start is sda fall with scl high
// R13: watch for start except while programming
// R14: stop is sda rise with scl high
// R15: nack then stop returns to standby
// R16: stop after write data starts programming
// R17: transmitter releases sda, receiver acks ninth
// R18: sample on scl rise, change while low
// R19: respond only when chip field matches pins
// R20: select bit zero: one read, zero write
// R21: match acks, mismatch releases until start
// R22: reads continue, independent of write protect
// R23: up to 128 bytes per page program
// R24: random read: address write then restart
// R25: sda released unless pulling low
`default_nettype none
`include "seesf_map.svh"

module seesf_top #(
   parameter logic [3:0] P_TYPE_ID      = 4'h5,                  // arbitrary identifier value
   parameter int         P_WRITE_TIME_NS = `SEESF_WRITE_TIME_NS  // self-timed program time
) (
   input  wire logic i_clk,                  // core clock, 250 MHz
   input  wire logic i_reset_n,              // synchronous reset, active low
   input  wire logic i_ce,                   // clock enable, freezes core state
   input  wire logic i_scl,                  // serial clock from master
   input  wire logic i_sda,                  // serial data pin level
   output logic      o_sda_out,              // serial data drive value
   output logic      o_sda_oe_n,             // low while pulling serial data low
   input  wire logic i_chip_addr_pin_lsb,    // chip address strap, select bit b1
   input  wire logic i_chip_addr_pin_mid,    // chip address strap, select bit b2
   input  wire logic i_chip_addr_pin_msb,    // chip address strap, select bit b3
   input  wire logic i_write_protect_input,  // high at the end of the address blocks array writes
   input  wire logic i_supply_good,          // supply above power-on threshold
   output logic      o_write_busy,           // internal program cycle running
   output logic      o_selected              // device addressed in a transfer
);
   import seesf_pkg::*;

   localparam int WRITE_CYCLES_RAW = P_WRITE_TIME_NS / `SEESF_CLK_PERIOD_NS;
   localparam int WRITE_CYCLES = (WRITE_CYCLES_RAW < `SEESF_PAGE_BYTES) ?
                                 `SEESF_PAGE_BYTES : WRITE_CYCLES_RAW;
   localparam logic [15:0] WRITE_LAST = 16'(WRITE_CYCLES - 1);

   // ----------------------------------------------------------------
   // link domain: bits shifted on the master's clock
   // ----------------------------------------------------------------
   seesf_byte_t link_shift;

   // R18 sample on rise
   always_ff @(posedge i_scl) begin
      link_shift <= {link_shift[6:0], i_sda};
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [`SEESF_PIN_W-1:0] pin_raw;
   logic [`SEESF_PIN_W-1:0] pin_s1;
   logic [`SEESF_PIN_W-1:0] pin_s2;
   logic [`SEESF_PIN_W-1:0] pin_s3;
   logic [`SEESF_PIN_W-1:0] pin_f;
   logic [`SEESF_PIN_W-1:0] pin_f_d;

   assign pin_raw = {i_chip_addr_pin_msb, i_chip_addr_pin_mid, i_chip_addr_pin_lsb,
                     i_supply_good, i_write_protect_input, i_sda, i_scl};

   // a level counts only once stages two and three agree
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         pin_s1  <= `SEESF_PIN_RESET;
         pin_s2  <= `SEESF_PIN_RESET;
         pin_s3  <= `SEESF_PIN_RESET;
         pin_f   <= `SEESF_PIN_RESET;
         pin_f_d <= `SEESF_PIN_RESET;
      end else if (i_ce) begin
         pin_s1  <= pin_raw;
         pin_s2  <= pin_s1;
         pin_s3  <= pin_s2;
         pin_f   <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
         pin_f_d <= pin_f;
      end
   end

   logic       scl_now;
   logic       scl_was;
   logic       sda_now;
   logic       sda_was;
   logic       wp_now;
   logic       pg_now;
   logic [2:0] chip_pins;
   logic       scl_rise;
   logic       scl_fall;
   logic       bus_start;
   logic       bus_stop;

   assign scl_now   = pin_f[`SEESF_PIN_SCL];
   assign scl_was   = pin_f_d[`SEESF_PIN_SCL];
   assign sda_now   = pin_f[`SEESF_PIN_SDA];
   assign sda_was   = pin_f_d[`SEESF_PIN_SDA];
   assign wp_now    = pin_f[`SEESF_PIN_WP];
   assign pg_now    = pin_f[`SEESF_PIN_PG];
   // R07 strap order msb, mid, lsb
   assign chip_pins = pin_f[`SEESF_PIN_CHIP_MSB:`SEESF_PIN_CHIP_LSB];
   assign scl_rise  = scl_now & ~scl_was;
   assign scl_fall  = ~scl_now & scl_was;
   // R12 start detect
   assign bus_start = scl_now & scl_was & sda_was & ~sda_now;
   // R14 stop detect
   assign bus_stop  = scl_now & scl_was & ~sda_was & sda_now;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   // R01 full array
   seesf_byte_t mem [0:(1 << `SEESF_ADDR_W)-1];
   seesf_byte_t page_data [0:`SEESF_PAGE_BYTES-1];
   logic [`SEESF_PAGE_BYTES-1:0] page_valid;

   // ----------------------------------------------------------------
   // protocol state
   // ----------------------------------------------------------------
   seesf_state_e         state;
   logic [3:0]           bit_cnt;
   logic                 ack_pend;
   logic                 drive_low;
   seesf_byte_t          tx_byte;
   seesf_byte_t          addr_hi;
   seesf_addr_t          addr_ptr;
   logic                 wp_lat;
   logic                 have_data;
   logic                 start_prog;
   logic [`SEESF_ROW_W-1:0] prog_row;
   logic                 busy;
   logic                 sel_match;
   logic                 new_bit;

   // R10 type, chip field and direction
   // R19 chip field against straps
   assign sel_match = (link_shift[`SEESF_SEL_TYPE_MSB:`SEESF_SEL_TYPE_LSB] == P_TYPE_ID) &&
                      (link_shift[`SEESF_SEL_CHIP_MSB:`SEESF_SEL_CHIP_LSB] == chip_pins);
   assign new_bit   = tx_byte[3'(`SEESF_LAST_DATA_BIT - bit_cnt)];

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         state      <= SEESF_IDLE;
         bit_cnt    <= 4'h0;
         ack_pend   <= 1'b0;
         drive_low  <= 1'b0;
         tx_byte    <= 8'hff;
         addr_hi    <= 8'h00;
         addr_ptr   <= 16'h0000;
         wp_lat     <= 1'b0;
         have_data  <= 1'b0;
         start_prog <= 1'b0;
         prog_row   <= 9'h000;
         page_valid <= '0;
      end else if (i_ce) begin
         start_prog <= 1'b0;
         // R06 gate on supply
         // R13 bus ignored while programming
         if (!pg_now || busy) begin
            state     <= SEESF_IDLE;
            drive_low <= 1'b0;
            ack_pend  <= 1'b0;
         end else if (bus_stop) begin
            // R16 stop right after a data ack
            if (state == SEESF_WDATA && bit_cnt == `SEESF_STOP_SLOT && have_data && !wp_lat) begin
               start_prog <= 1'b1;
               prog_row   <= addr_ptr[`SEESF_ADDR_W-1:`SEESF_COL_W];
            end
            // R15 back to standby
            state     <= SEESF_IDLE;
            drive_low <= 1'b0;
            ack_pend  <= 1'b0;
         end else if (bus_start) begin
            // R24 repeated start from any state
            state     <= SEESF_SELECT;
            bit_cnt   <= 4'h0;
            drive_low <= 1'b0;
            ack_pend  <= 1'b0;
         end else if (state != SEESF_IDLE && scl_rise) begin
            if (bit_cnt == `SEESF_ACK_SLOT) begin
               bit_cnt <= 4'h0;
               if (state == SEESF_RDATA) begin
                  // R05 master nack ends the read, own select ack never does
                  if (sda_now && !drive_low) begin
                     state <= SEESF_IDLE;
                  end else begin
                     // R22 first or next byte in sequence
                     tx_byte  <= mem[addr_ptr];
                     addr_ptr <= addr_ptr + 16'h0001;
                  end
               end
            end else begin
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == `SEESF_LAST_DATA_BIT) begin
                  case (state)
                     SEESF_SELECT: begin
                        if (sel_match) begin
                           // R21 match acknowledged
                           ack_pend <= 1'b1;
                           // R20 direction bit
                           if (link_shift[`SEESF_SEL_RW_BIT]) begin
                              // first byte fetched in the ack slot
                              state <= SEESF_RDATA;
                           end else begin
                              state <= SEESF_ADDR_HI;
                           end
                        end else begin
                           // R21 mismatch drops to standby
                           state <= SEESF_IDLE;
                        end
                     end
                     SEESF_ADDR_HI: begin
                        // R11 high byte first
                        addr_hi  <= link_shift;
                        ack_pend <= 1'b1;
                        state    <= SEESF_ADDR_LO;
                     end
                     SEESF_ADDR_LO: begin
                        addr_ptr   <= {addr_hi, link_shift};
                        ack_pend   <= 1'b1;
                        // protect level settles by the end of the address
                        wp_lat     <= wp_now;
                        have_data  <= 1'b0;
                        page_valid <= '0;
                        state      <= SEESF_WDATA;
                     end
                     SEESF_WDATA: begin
                        // R08 protected data never latched
                        // R09 and never acknowledged
                        if (!wp_lat) begin
                           // R23 column wraps inside the row
                           page_data[addr_ptr[`SEESF_COL_W-1:0]]  <= link_shift;
                           page_valid[addr_ptr[`SEESF_COL_W-1:0]] <= 1'b1;
                           addr_ptr[`SEESF_COL_W-1:0] <=
                              addr_ptr[`SEESF_COL_W-1:0] + 7'h01;
                           have_data <= 1'b1;
                           // R04 ack each received byte
                           ack_pend  <= 1'b1;
                        end
                     end
                     default: begin
                        ack_pend <= 1'b0;
                     end
                  endcase
               end
            end
         end else if (state != SEESF_IDLE && scl_fall) begin
            // R18 drive changes only while scl low
            if (bit_cnt == `SEESF_ACK_SLOT) begin
               // R17 pull low in the ninth slot
               drive_low <= ack_pend;
               ack_pend  <= 1'b0;
            end else if (state == SEESF_RDATA) begin
               drive_low <= ~new_bit;
            end else begin
               // R17 release while the master sends
               drive_low <= 1'b0;
            end
         end else if (state == SEESF_IDLE) begin
            // R25 released in standby
            drive_low <= 1'b0;
            ack_pend  <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // self-timed program cycle
   // ----------------------------------------------------------------
   logic [`SEESF_COL_W-1:0] prog_idx;
   logic                    prog_sweep;
   logic [15:0]             prog_timer;

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         busy       <= 1'b0;
         prog_idx   <= 7'h00;
         prog_sweep <= 1'b0;
         prog_timer <= 16'h0000;
      end else if (i_ce) begin
         if (start_prog) begin
            busy       <= 1'b1;
            prog_idx   <= 7'h00;
            prog_sweep <= 1'b1;
            prog_timer <= 16'h0000;
         end else if (busy) begin
            if (prog_sweep) begin
               prog_idx <= prog_idx + 7'h01;
               if (prog_idx == `SEESF_PAGE_LAST) begin
                  prog_sweep <= 1'b0;
               end
            end
            // busy lasts the full program time, not just the sweep
            if (prog_timer == WRITE_LAST) begin
               busy <= 1'b0;
            end else begin
               prog_timer <= prog_timer + 16'h0001;
            end
         end
      end
   end

   // R23 one cycle programs the whole latched page
   always_ff @(posedge i_clk) begin
      if (i_ce && busy && prog_sweep && page_valid[prog_idx]) begin
         mem[{prog_row, prog_idx}] <= page_data[prog_idx];
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_selected <= 1'b0;
      end else if (i_ce) begin
         o_selected <= (state != SEESF_IDLE) && (state != SEESF_SELECT);
      end
   end

   // R02 open drain only, never a driven high
   assign o_sda_out    = 1'b0;
   // R25 enable low only when pulling low
   assign o_sda_oe_n   = ~drive_low;
   assign o_write_busy = busy;

endmodule
`default_nettype wire

// file: sim/seesf_checker.sv
// assertion checker for the serial eeprom slave front
`default_nettype none
// ------------------------------------
// checker
// ------------------------------------
module seesf_checker #(
   parameter int P_WRITE_TIME_NS = 5000  // program time
) (
   input wire logic i_clk,                  // core clock
   input wire logic i_reset_n,              // sync reset, active low
   input wire logic i_ce,                   // clock enable
   input wire logic i_scl,                  // serial clock
   input wire logic i_sda,                  // data wire level
   input wire logic o_sda_out,              // data drive value
   input wire logic o_sda_oe_n,             // low while pulling low
   input wire logic i_chip_addr_pin_lsb,    // strap b1
   input wire logic i_chip_addr_pin_mid,    // strap b2
   input wire logic i_chip_addr_pin_msb,    // strap b3
   input wire logic i_write_protect_input,  // write protect
   input wire logic i_supply_good,          // supply ok
   input wire logic o_write_busy,           // program cycle
   input wire logic o_selected              // addressed
);
   timeunit 1ns;
   timeprecision 100ps;
   // short program times clamp to the floor count
   localparam int WC = (P_WRITE_TIME_NS / 4 < 128) ? 128 : P_WRITE_TIME_NS / 4;
   int busy_cnt;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   always_ff @(posedge i_clk) begin
      // frozen core holds its count as the design holds its timer
      if (!i_reset_n) begin
         busy_cnt <= 0;
      end else if (i_ce) begin
         busy_cnt <= o_write_busy ? busy_cnt + 1 : 0;
      end
   end
   a_drive_zero: assert property (o_sda_out == 1'b0)
      else $error("data drive value not zero");
   a_busy_release: assert property (o_write_busy |-> o_sda_oe_n)
      else $error("data driven during program cycle");
   a_busy_unsel: assert property (o_write_busy |-> !o_selected)
      else $error("selected during program cycle");
   a_drive_scl_low: assert property ($fell(o_sda_oe_n) |-> !i_scl)
      else $error("data drive began with clock high");
   a_steady_scl_high: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe_n))
      else $error("data drive changed with clock high");
   a_program_length: assert property ($fell(o_write_busy) |-> busy_cnt == WC)
      else $error("program cycle length wrong");
   a_protect_no_prog: assert property (i_write_protect_input [*8] |-> !$rose(o_write_busy))
      else $error("program cycle under write protect");
   a_unpowered_deaf: assert property (!i_supply_good [*8] |-> !$rose(o_selected))
      else $error("selected with supply low");
   a_reset_idle: assert property ($rose(i_reset_n) |-> o_sda_oe_n && !o_write_busy && !o_selected)
      else $error("outputs not idle after reset");
   c_program: cover property ($rose(o_write_busy));
   c_ack: cover property ($fell(o_sda_oe_n));
   c_select: cover property ($rose(o_selected));
endmodule
bind seesf_top seesf_checker #(.P_WRITE_TIME_NS(P_WRITE_TIME_NS)) u_chk (.i_clk, .i_reset_n,
   .i_ce, .i_scl, .i_sda, .o_sda_out, .o_sda_oe_n, .i_chip_addr_pin_lsb, .i_chip_addr_pin_mid,
   .i_chip_addr_pin_msb, .i_write_protect_input, .i_supply_good, .o_write_busy, .o_selected);
`default_nettype wire

// file: sim/seesf_master.sv
// two-wire bus master model facing the eeprom front
`default_nettype none
// ------------------------------------
// bus master
// ------------------------------------
module seesf_master (
   input  wire logic  i_lclk,      // link tick clock
   input  wire logic  i_sda,       // resolved data wire
   output logic       o_scl,       // serial clock, still between frames
   output logic       o_sda_oe_n,  // low while pulling data low
   output logic       o_res_stb,   // pulse per finished byte slot
   output logic [8:0] o_res        // sampled byte and ninth bit
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      o_scl = 1'b1;
      o_sda_oe_n = 1'b1;
      o_res_stb = 1'b0;
      o_res = 9'h0;
   end
   task automatic tk(input int n);
      repeat (n) @(posedge i_lclk);
   endtask
   task automatic start();
      tk(1);
      o_scl <= 1'b0;
      tk(1);
      o_sda_oe_n <= 1'b1;
      tk(2);
      o_scl <= 1'b1;
      tk(3);
      o_sda_oe_n <= 1'b0;
      tk(3);
   endtask
   // change while clock low, ninth bit carries ack
   task automatic xfer(input logic [8:0] tx);
      for (int i = 8; i >= 0; i--) begin
         o_scl <= 1'b0;
         tk(1);
         o_sda_oe_n <= tx[i];
         tk(2);
         o_scl <= 1'b1;
         tk(1);
         o_res[i] <= i_sda;
         tk(2);
      end
      o_res_stb <= 1'b1;
      tk(1);
      o_res_stb <= 1'b0;
   endtask
   task automatic stop();
      tk(1);
      o_scl <= 1'b0;
      tk(1);
      o_sda_oe_n <= 1'b0;
      tk(2);
      o_scl <= 1'b1;
      tk(3);
      o_sda_oe_n <= 1'b1;
      tk(3);
   endtask
endmodule
`default_nettype wire

// file: sim/seesf_top_tb.sv
// self-checking bench for the serial eeprom slave front
`default_nettype none
// ------------------------------------
// bench top
// ------------------------------------
module seesf_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import seesf_pkg::*;
   localparam int         WT  = 4000;
   localparam logic [3:0] TID = 4'h5;  // arbitrary identifier value
   logic        clk, lclk, rst_n, ce, scl, m_oe_n, d_oe_n, sda_out, wp, pg, busy, sel, stb;
   logic [2:0]  pins;
   logic [8:0]  res;
   logic [8:0]  exp_q[$];
   logic [15:0] a;
   seesf_byte_t d0, d1;
   int          err_count = 0, check_count = 0, seed = 78318, cyc = 0;
   // open drain wire with pull-up
   wire logic   sda = m_oe_n & d_oe_n;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      lclk = 1'b0;
      #1.3;
      forever #7.5 lclk = ~lclk;
   end
   seesf_top #(.P_TYPE_ID(TID), .P_WRITE_TIME_NS(WT)) dut (.i_clk(clk), .i_reset_n(rst_n),
      .i_ce(ce), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe_n(d_oe_n),
      .i_chip_addr_pin_lsb(pins[0]), .i_chip_addr_pin_mid(pins[1]),
      .i_chip_addr_pin_msb(pins[2]), .i_write_protect_input(wp), .i_supply_good(pg),
      .o_write_busy(busy), .o_selected(sel));
   seesf_master m (.i_lclk(lclk), .i_sda(sda), .o_scl(scl), .o_sda_oe_n(m_oe_n),
      .o_res_stb(stb), .o_res(res));
   task automatic chk(input logic [8:0] seen, input logic [8:0] expv);
      check_count++;
      if (seen !== expv) begin
         err_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, expv);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_busy(input logic v, input int n);
      for (int i = 0; i < n && busy !== v; i++) @(posedge clk);
      #1;
   endtask
   function automatic seesf_byte_t sb(input logic rw);
      return {TID, pins, rw};
   endfunction
   // master writes a byte, ninth bit expected from the device
   task automatic tx(input seesf_byte_t d, input logic ak);
      exp_q.push_back({d, ak});
      m.xfer({d, 1'b1});
   endtask
   // device sends a byte, master answers with mak
   task automatic rx(input seesf_byte_t d, input logic mak);
      exp_q.push_back({d, mak});
      m.xfer({8'hff, mak});
   endtask
   task automatic addr();
      m.start();
      tx(sb(1'b0), 1'b0);
      tx(a[15:8], 1'b0);
      tx(a[7:0], 1'b0);
   endtask
   always @(posedge stb) begin
      chk(res, exp_q.size() > 0 ? exp_q.pop_front() : ~res);
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         $display("MISMATCH t=%0t run too long", $time);
         final_report();
      end
   end
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      wp = 1'b0;
      pg = 1'b1;
      pins = 3'($random(seed));
      d0 = 8'($random(seed));
      d1 = 8'($random(seed));
      a = 16'($random(seed)) & 16'hfffe;
      step(10);
      chk({5'h0, sda_out, d_oe_n, busy, sel}, 9'h004);
      rst_n = 1'b1;
      step(8);
      addr();
      chk(9'(sel), 9'h001);
      tx(d0, 1'b0);
      tx(d1, 1'b0);
      m.stop();
      wait_busy(1'b1, 30);
      chk(9'(busy), 9'h001);
      m.start();
      tx(sb(1'b0), 1'b1);
      m.stop();
      $display("write test done");
      wait_busy(1'b0, 1200);
      chk(9'(busy), 9'h000);
      addr();
      m.start();
      tx(sb(1'b1), 1'b0);
      rx(d0, 1'b0);
      rx(d1, 1'b1);
      m.stop();
      $display("read test done");
      for (int i = 0; i < 2; i++) begin
         m.start();
         tx(i ? sb(1'b0) ^ 8'h02 : sb(1'b0) ^ 8'h80, 1'b1);
         tx(a[15:8], 1'b1);
         m.stop();
      end
      // frozen core must miss a whole transfer
      step(1);
      ce = 1'b0;
      m.start();
      tx(sb(1'b0), 1'b1);
      m.stop();
      step(1);
      ce = 1'b1;
      $display("mismatch test done");
      step(1);
      wp = 1'b1;
      addr();
      tx(~d0, 1'b1);
      m.stop();
      wait_busy(1'b1, 40);
      chk(9'(busy), 9'h000);
      addr();
      m.start();
      tx(sb(1'b1), 1'b0);
      rx(d0, 1'b1);
      m.stop();
      step(1);
      wp = 1'b0;
      pg = 1'b0;
      $display("protect test done");
      step(10);
      m.start();
      tx(sb(1'b1), 1'b1);
      m.stop();
      $display("supply test done");
      final_report();
   end
endmodule
`default_nettype wire
